// *** inc/timer8_pkg.sv ***
// package: register map, field layouts and carrier types of the timer
package timer8_pkg;
   localparam int ADDR_W = 8;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_COUNT = 8'h04;
   localparam logic [7:0] ADDR_COMPARE = 8'h08;
   localparam logic [7:0] ADDR_FLAGS = 8'h0C;
   localparam int FLAG_WRAP_BIT = 0;
   localparam int FLAG_MATCH_BIT = 1;
   localparam int FORCE_BIT = 7;
   localparam logic [7:0] CNT_MAX = 8'hFF;
   localparam logic [7:0] CNT_BOTTOM = 8'h00;
   localparam logic [7:0] CNT_ONE = 8'h01;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] COMPARE_RESET = 8'h00;
   localparam logic [2:0] CS_STOP = 3'h0;
   localparam logic [2:0] CS_DIV1 = 3'h1;
   localparam logic [2:0] CS_DIV8 = 3'h2;
   localparam logic [2:0] CS_DIV64 = 3'h3;
   localparam logic [2:0] CS_DIV256 = 3'h4;
   localparam logic [2:0] CS_DIV1024 = 3'h5;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;
   localparam int PRE_W = 10;
   localparam logic [9:0] PRE_MASK8 = 10'h007;
   localparam logic [9:0] PRE_MASK64 = 10'h03F;
   localparam logic [9:0] PRE_MASK256 = 10'h0FF;
   localparam logic [9:0] PRE_MASK1024 = 10'h3FF;
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_TOGGLE = 2'h1;
   localparam logic [1:0] ACT_CLEAR = 2'h2;
   localparam logic [1:0] ACT_SET = 2'h3;
   typedef enum logic [1:0] {
      MODE_NORMAL = 2'h0,
      MODE_PC_PWM = 2'h1,
      MODE_CLEAR_MATCH = 2'h2,
      MODE_FAST_PWM = 2'h3
   } wave_mode_t;
   typedef enum logic {
      DIR_UP = 1'b0,
      DIR_DOWN = 1'b1
   } dir_t;
   // control word: bit 7 strobe, 6:5 action, 4:3 mode, 2:0 clock source
   typedef struct packed {
      logic force_cmp;
      logic [1:0] output_action_sel;
      wave_mode_t waveform_mode_sel;
      logic [2:0] clock_source_sel;
   } ctrl_t;
   localparam ctrl_t CTRL_RESET = '{1'b0, ACT_NONE, MODE_NORMAL, CS_STOP};
endpackage

// *** src/tick_gen.sv ***
// timer clock enable from the prescaler taps or the external count pin
`timescale 1ns/1ps
`default_nettype none
module tick_gen (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic [2:0] clock_source_sel,
   input wire logic ext_clk_pin,
   output logic tick
);
   logic [timer8_pkg::PRE_W-1:0] pre_reg;
   logic pin_reg;
   logic sel;

   function automatic logic tap(input logic [9:0] c, input logic [9:0] m);
      tap = (c & m) == m;
   endfunction

   // free running prescaler
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_reg <= '0;
      end else if (clk_en) begin
         pre_reg <= pre_reg + 10'h001;
      end
   end

   // previous pin level for edge detection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_reg <= 1'b0;
      end else if (clk_en) begin
         pin_reg <= ext_clk_pin;
      end
   end

   // source select; stop gives no tick at all
   always_comb begin
      case (clock_source_sel)
         timer8_pkg::CS_DIV1: sel = 1'b1;
         timer8_pkg::CS_DIV8: sel = tap(pre_reg, timer8_pkg::PRE_MASK8);
         timer8_pkg::CS_DIV64: sel = tap(pre_reg, timer8_pkg::PRE_MASK64);
         timer8_pkg::CS_DIV256: sel = tap(pre_reg, timer8_pkg::PRE_MASK256);
         timer8_pkg::CS_DIV1024: sel = tap(pre_reg, timer8_pkg::PRE_MASK1024);
         timer8_pkg::CS_EXT_FALL: sel = pin_reg & ~ext_clk_pin;
         timer8_pkg::CS_EXT_RISE: sel = ~pin_reg & ext_clk_pin;
         default: sel = 1'b0;
      endcase
      tick = clk_en & sel;
   end
endmodule
`default_nettype wire

// *** src/compare_buffer.sv ***
// compare value with optional double buffer
`timescale 1ns/1ps
`default_nettype none
module compare_buffer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic buffered,
   input wire logic wr,
   input wire logic [7:0] wdata,
   input wire logic load,
   output logic [7:0] active,
   output logic [7:0] shadow
);
   // software always writes the buffer; direct modes also the active copy
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shadow <= timer8_pkg::COMPARE_RESET;
         active <= timer8_pkg::COMPARE_RESET;
      end else if (clk_en) begin
         if (wr) begin
            shadow <= wdata;
         end
         if (wr && !buffered) begin
            active <= wdata;
         end else if (load && buffered) begin
            active <= shadow;
         end
      end
   end
endmodule
`default_nettype wire

// *** src/timer8_apb.sv ***
// 8-bit timer with one compare channel and four waveform modes, apb slave
`timescale 1ns/1ps
`default_nettype none
module timer8_apb (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_clk_pin,
   input wire logic wrap_ack,
   input wire logic match_ack,
   output logic wave_out_bit,
   output logic wave_out_en,
   output logic wrap_flag,
   output logic match_flag
);
   timer8_pkg::ctrl_t ctrl_reg;
   timer8_pkg::dir_t dir_reg;
   timer8_pkg::dir_t dir_next;
   timer8_pkg::wave_mode_t mode;
   logic [7:0] count_reg;
   logic [7:0] count_next;
   logic [7:0] cmp_active;
   logic [7:0] cmp_shadow;
   logic [1:0] act;
   logic block_reg;
   logic up_seen_reg;
   logic up_seen_next;
   logic pend_reg;
   logic pend_next;
   logic out_next;
   logic tick;
   logic access;
   logic commit;
   logic ctrl_wr;
   logic cnt_wr;
   logic cmp_wr;
   logic flag_wr;
   logic force_now;
   logic pwm;
   logic hit;
   logic eff_up;
   logic at_top;
   logic at_bottom;
   logic cmp_load;
   logic wrap_set;
   logic wrap_clr;
   logic match_clr;
   logic [31:0] rd_data;

   function automatic logic apply_act(input logic [1:0] a, input logic o);
      case (a)
         timer8_pkg::ACT_TOGGLE: apply_act = ~o;
         timer8_pkg::ACT_CLEAR: apply_act = 1'b0;
         timer8_pkg::ACT_SET: apply_act = 1'b1;
         default: apply_act = o;
      endcase
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == timer8_pkg::ADDR_CTRL) ||
               (a == timer8_pkg::ADDR_COUNT) ||
               (a == timer8_pkg::ADDR_COMPARE) ||
               (a == timer8_pkg::ADDR_FLAGS);
   endfunction

   // bus strobes; writes land on the edge where pready is sampled
   assign access = psel & penable;
   assign commit = access & pready & clk_en & pwrite & mapped(paddr);
   assign ctrl_wr = commit & (paddr == timer8_pkg::ADDR_CTRL);
   assign cnt_wr = commit & (paddr == timer8_pkg::ADDR_COUNT);
   assign cmp_wr = commit & (paddr == timer8_pkg::ADDR_COMPARE);
   assign flag_wr = commit & (paddr == timer8_pkg::ADDR_FLAGS);
   assign force_now = ctrl_wr & pwdata[timer8_pkg::FORCE_BIT] & ~pwm;

   // mode decode and compare detection
   assign mode = ctrl_reg.waveform_mode_sel;
   assign act = ctrl_reg.output_action_sel;
   assign pwm = (mode == timer8_pkg::MODE_PC_PWM) ||
                (mode == timer8_pkg::MODE_FAST_PWM);
   assign hit = (count_reg == cmp_active) & ~block_reg;
   assign at_top = count_reg == timer8_pkg::CNT_MAX;
   assign at_bottom = count_reg == timer8_pkg::CNT_BOTTOM;
   assign eff_up = at_bottom | (dir_reg == timer8_pkg::DIR_UP & ~at_top);

   // read mux
   always_comb begin
      case (paddr)
         timer8_pkg::ADDR_CTRL: rd_data = {24'h000000, ctrl_reg};
         timer8_pkg::ADDR_COUNT: rd_data = {24'h000000, count_reg};
         timer8_pkg::ADDR_COMPARE: rd_data = {24'h000000, cmp_shadow};
         timer8_pkg::ADDR_FLAGS: rd_data = {30'h00000000, match_flag,
                                            wrap_flag};
         default: rd_data = 32'h00000000;
      endcase
   end

   // apb answer: one wait cycle, then pready with data or error
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else if (clk_en) begin
         pready <= access & ~pready;
         pslverr <= access & ~pready & ~mapped(paddr);
         if (access && !pready) begin
            prdata <= rd_data;
         end
      end
   end

   // control register; the force bit is a strobe and stays zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= timer8_pkg::CTRL_RESET;
         wave_out_en <= 1'b0;
      end else if (ctrl_wr) begin
         ctrl_reg <= {1'b0, pwdata[6:0]};
         wave_out_en <= pwdata[6] | pwdata[5];
      end
   end

   tick_gen u_tick (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .clock_source_sel(ctrl_reg.clock_source_sel),
      .ext_clk_pin(ext_clk_pin),
      .tick(tick)
   );

   // buffer update point per pwm mode
   assign cmp_load = tick & ~cnt_wr & at_top &
      ((mode == timer8_pkg::MODE_FAST_PWM) |
       (mode == timer8_pkg::MODE_PC_PWM & dir_reg == timer8_pkg::DIR_UP));

   compare_buffer u_cmp (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .buffered(pwm),
      .wr(cmp_wr),
      .wdata(pwdata[7:0]),
      .load(cmp_load),
      .active(cmp_active),
      .shadow(cmp_shadow)
   );

   // next count and direction from waveform mode, compare match and count direction
   always_comb begin
      dir_next = timer8_pkg::DIR_UP;
      case (mode)
         timer8_pkg::MODE_CLEAR_MATCH: begin
            count_next = hit ? timer8_pkg::CNT_BOTTOM
                             : count_reg + timer8_pkg::CNT_ONE;
         end
         timer8_pkg::MODE_PC_PWM: begin
            dir_next = at_top ? timer8_pkg::DIR_DOWN
                     : at_bottom ? timer8_pkg::DIR_UP : dir_reg;
            if (eff_up) begin
               count_next = count_reg + timer8_pkg::CNT_ONE;
            end else begin
               count_next = count_reg - timer8_pkg::CNT_ONE;
            end
         end
         default: count_next = count_reg + timer8_pkg::CNT_ONE;
      endcase
   end

   // counter: software write wins over counting
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_reg <= timer8_pkg::COUNT_RESET;
         dir_reg <= timer8_pkg::DIR_UP;
      end else if (cnt_wr) begin
         count_reg <= pwdata[7:0];
      end else if (tick) begin
         count_reg <= count_next;
         dir_reg <= dir_next;
      end
   end

   // match block after a count write, consumed by the next tick
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         block_reg <= 1'b0;
      end else if (cnt_wr) begin
         block_reg <= 1'b1;
      end else if (tick) begin
         block_reg <= 1'b0;
      end
   end

   // wrap condition by mode
   always_comb begin
      case (mode)
         timer8_pkg::MODE_PC_PWM:
            wrap_set = count_next == timer8_pkg::CNT_BOTTOM;
         timer8_pkg::MODE_FAST_PWM:
            wrap_set = count_next == timer8_pkg::CNT_MAX;
         default:
            wrap_set = at_top & (count_next == timer8_pkg::CNT_BOTTOM);
      endcase
   end
   assign wrap_clr = wrap_ack | (flag_wr & pwdata[timer8_pkg::FLAG_WRAP_BIT]);
   assign match_clr = match_ack |
                      (flag_wr & pwdata[timer8_pkg::FLAG_MATCH_BIT]);

   // sticky flags; a set in the clearing cycle wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wrap_flag <= 1'b0;
         match_flag <= 1'b0;
      end else if (clk_en) begin
         wrap_flag <= (tick & ~cnt_wr & wrap_set) |
                      (wrap_flag & ~wrap_clr);
         match_flag <= (tick & hit) | (match_flag & ~match_clr);
      end
   end

   // waveform generator
   always_comb begin
      out_next = wave_out_bit;
      up_seen_next = up_seen_reg;
      pend_next = pend_reg;
      if (force_now) begin
         out_next = apply_act(act, wave_out_bit);
      end else if (tick) begin
         case (mode)
            timer8_pkg::MODE_FAST_PWM: begin
               if (act == timer8_pkg::ACT_TOGGLE) begin
                  out_next = hit ? ~wave_out_bit : wave_out_bit;
               end else if (act[1] && at_top) begin
                  out_next = ~act[0];
               end else if (act[1] && hit) begin
                  out_next = act[0];
               end
            end
            timer8_pkg::MODE_PC_PWM: begin
               if (at_bottom && dir_reg == timer8_pkg::DIR_DOWN) begin
                  up_seen_next = 1'b0;
                  pend_next = 1'b0;
                  if (act[1] && pend_reg) begin
                     out_next = act[0];
                  end
               end
               if (act[1] && hit && cmp_active != timer8_pkg::CNT_MAX) begin
                  out_next = eff_up ? act[0] : ~act[0];
                  up_seen_next = up_seen_next | eff_up;
               end
               if (act[1] && at_top && dir_reg == timer8_pkg::DIR_UP) begin
                  pend_next = (cmp_active == timer8_pkg::CNT_MAX) &
                              (cmp_shadow != timer8_pkg::CNT_MAX);
                  if (cmp_active == timer8_pkg::CNT_MAX) begin
                     out_next = ~act[0];
                  end else if (!up_seen_reg) begin
                     out_next = act[0];
                  end
               end
            end
            default: begin
               if (hit) begin
                  out_next = apply_act(act, wave_out_bit);
               end
            end
         endcase
      end
   end

   // output level and symmetry bookkeeping
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wave_out_bit <= 1'b0;
         up_seen_reg <= 1'b0;
         pend_reg <= 1'b0;
      end else if (clk_en) begin
         wave_out_bit <= out_next;
         up_seen_reg <= up_seen_next;
         pend_reg <= pend_next;
      end
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_norm_step;
      tick && !cnt_wr && mode == timer8_pkg::MODE_NORMAL |=>
         count_reg == $past(count_reg) + 8'h01;
   endproperty
   a_norm_step: assert property (p_norm_step)
      else $error("normal mode did not increment");

   property p_norm_wrap;
      tick && !cnt_wr && mode == timer8_pkg::MODE_NORMAL && at_top |=>
         count_reg == 8'h00 && wrap_flag;
   endproperty
   a_norm_wrap: assert property (p_norm_wrap)
      else $error("wrap flag missing at zero");

   property p_flag_hold;
      wrap_flag && !wrap_clr |=> wrap_flag;
   endproperty
   a_flag_hold: assert property (p_flag_hold)
      else $error("wrap flag lost without a clear");

   property p_cm_clear;
      tick && !cnt_wr && mode == timer8_pkg::MODE_CLEAR_MATCH && hit |=>
         count_reg == 8'h00;
   endproperty
   a_cm_clear: assert property (p_cm_clear)
      else $error("counter not cleared on match");

   property p_cm_toggle;
      tick && !force_now && mode == timer8_pkg::MODE_CLEAR_MATCH &&
         act == 2'h1 && hit |=> wave_out_bit != $past(wave_out_bit);
   endproperty
   a_cm_toggle: assert property (p_cm_toggle)
      else $error("output did not toggle on match");

   property p_fast_restart;
      tick && !cnt_wr && mode == timer8_pkg::MODE_FAST_PWM && at_top |=>
         count_reg == 8'h00;
   endproperty
   a_fast_restart: assert property (p_fast_restart)
      else $error("fast pwm did not restart at zero");

   property p_fast_bottom;
      tick && mode == timer8_pkg::MODE_FAST_PWM && act == 2'h2 && at_top
         |=> wave_out_bit;
   endproperty
   a_fast_bottom: assert property (p_fast_bottom)
      else $error("fast pwm output not set at bottom");

   property p_pc_hold;
      tick && !cnt_wr && mode == timer8_pkg::MODE_PC_PWM && at_top &&
         dir_reg == timer8_pkg::DIR_UP |=>
         count_reg == 8'hFE && dir_reg == timer8_pkg::DIR_DOWN;
   endproperty
   a_pc_hold: assert property (p_pc_hold)
      else $error("phase-correct turn at max wrong");

   property p_pc_wrap;
      tick && !cnt_wr && mode == timer8_pkg::MODE_PC_PWM &&
         dir_reg == timer8_pkg::DIR_DOWN && count_reg == 8'h01 |=> wrap_flag;
   endproperty
   a_pc_wrap: assert property (p_pc_wrap)
      else $error("phase-correct wrap flag missing");

   property p_match_flag;
      tick && hit |=> match_flag;
   endproperty
   a_match_flag: assert property (p_match_flag)
      else $error("match flag not set");

   property p_block;
      cnt_wr |=> !hit;
   endproperty
   a_block: assert property (p_block)
      else $error("match not blocked after count write");

   property p_stopped;
      ctrl_reg.clock_source_sel == 3'h0 && !cnt_wr |=> $stable(count_reg);
   endproperty
   a_stopped: assert property (p_stopped)
      else $error("counter moved while stopped");

   property p_direct;
      cmp_wr && !pwm |=> cmp_active == $past(pwdata[7:0]);
   endproperty
   a_direct: assert property (p_direct)
      else $error("direct compare write not applied");

   c_pc_turn: cover property (tick && mode == timer8_pkg::MODE_PC_PWM &&
      at_bottom && dir_reg == timer8_pkg::DIR_DOWN);
   c_fast_spike: cover property (mode == timer8_pkg::MODE_FAST_PWM &&
      cmp_active == 8'h00 && $rose(wave_out_bit));
   c_cm_hit: cover property (tick && mode == timer8_pkg::MODE_CLEAR_MATCH &&
      hit);
   c_flag_race: cover property (tick && wrap_set && wrap_clr);
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// self-checking bench for the apb timer: bus tasks and mode scenarios
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic ext_clk_pin = 1'b0;
   logic clk_en = 1'b1;
   logic wrap_ack = 1'b0;
   logic match_ack = 1'b0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic wave_out_bit;
   logic wave_out_en;
   logic wrap_flag;
   logic match_flag;
   logic [31:0] q;
   logic err;
   int error_cnt = 0;
   int checks = 0;
   int cyc = 0;

   timer8_apb u_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext_clk_pin(ext_clk_pin), .wrap_ack(wrap_ack),
      .match_ack(match_ack), .wave_out_bit(wave_out_bit),
      .wave_out_en(wave_out_en), .wrap_flag(wrap_flag),
      .match_flag(match_flag));

   // 50 MHz clock
   always #10 pclk = ~pclk;

   // hang guard
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 30000) begin
         error_cnt++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("checks=%0d error_cnt=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(q, e);
   endtask

   // n pulses on the external count pin, one tick each
   task automatic tk(input int n);
      repeat (n) begin
         @(posedge pclk);
         ext_clk_pin <= 1'b1;
         repeat (2) @(posedge pclk);
         ext_clk_pin <= 1'b0;
         repeat (2) @(posedge pclk);
      end
      #1;
   endtask

   // control word: action, mode, external rising-edge count source
   function automatic logic [31:0] cw(input logic [1:0] act,
                                      input logic [1:0] md);
      return {25'h0, act, md, timer8_pkg::CS_EXT_RISE};
   endfunction

   // a prescaled source run for win pclk edges, then stopped
   task automatic pre_run(input logic [2:0] cs, input int win,
                          input logic [31:0] e);
      wr(timer8_pkg::ADDR_COUNT, 32'h0);
      wr(timer8_pkg::ADDR_CTRL, {29'h0, cs});
      repeat (win - 4) @(posedge pclk);
      wr(timer8_pkg::ADDR_CTRL, {29'h0, timer8_pkg::CS_STOP});
      rd(timer8_pkg::ADDR_COUNT, e);
   endtask

   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rd(timer8_pkg::ADDR_CTRL, 32'h0);
      rd(timer8_pkg::ADDR_FLAGS, 32'h0);
      apb(1'b0, 8'h10, 32'h0);
      chk({31'h0, err}, 32'h1);
      // stopped counter ignores pin edges but keeps its value
      wr(timer8_pkg::ADDR_COUNT, 32'hFE);
      tk(2);
      rd(timer8_pkg::ADDR_COUNT, 32'hFE);
      wr(timer8_pkg::ADDR_COMPARE, 32'h10);
      wr(timer8_pkg::ADDR_CTRL, cw(timer8_pkg::ACT_NONE, 2'h0));
      chk(wave_out_en, 1'b0);
      tk(1);
      chk(wrap_flag, 1'b0);
      tk(1);
      rd(timer8_pkg::ADDR_COUNT, 32'h00);
      chk(wrap_flag, 1'b1);
      tk(3);
      chk(wrap_flag, 1'b1);
      @(posedge pclk);
      wrap_ack <= 1'b1;
      @(posedge pclk);
      wrap_ack <= 1'b0;
      @(posedge pclk);
      #1;
      chk(wrap_flag, 1'b0);
      // count write equal to compare blocks the next match
      wr(timer8_pkg::ADDR_COUNT, 32'h10);
      tk(1);
      chk(match_flag, 1'b0);
      wr(timer8_pkg::ADDR_COUNT, 32'h0F);
      tk(2);
      chk(match_flag, 1'b1);
      rd(timer8_pkg::ADDR_COUNT, 32'h11);
      @(posedge pclk);
      match_ack <= 1'b1;
      @(posedge pclk);
      match_ack <= 1'b0;
      @(posedge pclk);
      #1;
      chk(match_flag, 1'b0);
      // clear-on-match with toggle
      wr(timer8_pkg::ADDR_COMPARE, 32'h03);
      wr(timer8_pkg::ADDR_CTRL, cw(timer8_pkg::ACT_TOGGLE, 2'h2));
      wr(timer8_pkg::ADDR_COUNT, 32'h00);
      tk(4);
      rd(timer8_pkg::ADDR_COUNT, 32'h00);
      chk(wave_out_bit, 1'b1);
      chk(wave_out_en, 1'b1);
      tk(4);
      chk(wave_out_bit, 1'b0);
      tk(2);
      wr(timer8_pkg::ADDR_COMPARE, 32'h01);
      tk(253);
      rd(timer8_pkg::ADDR_COUNT, 32'hFF);
      tk(1);
      chk(wrap_flag, 1'b1);
      tk(2);
      rd(timer8_pkg::ADDR_COUNT, 32'h00);
      // fast pwm, clear on match, set at bottom
      wr(timer8_pkg::ADDR_FLAGS, 32'h3);
      wr(timer8_pkg::ADDR_CTRL, cw(timer8_pkg::ACT_CLEAR, 2'h3));
      wr(timer8_pkg::ADDR_COMPARE, 32'h80);
      wr(timer8_pkg::ADDR_COUNT, 32'hFE);
      tk(1);
      chk(wrap_flag, 1'b1);
      tk(1);
      rd(timer8_pkg::ADDR_COUNT, 32'h00);
      chk(wave_out_bit, 1'b1);
      tk(128);
      chk(wave_out_bit, 1'b1);
      tk(1);
      chk(wave_out_bit, 1'b0);
      // phase-correct, set on up match, started above compare
      wr(timer8_pkg::ADDR_FLAGS, 32'h3);
      wr(timer8_pkg::ADDR_CTRL, cw(timer8_pkg::ACT_SET, 2'h1));
      wr(timer8_pkg::ADDR_COMPARE, 32'h02);
      wr(timer8_pkg::ADDR_COUNT, 32'hFE);
      tk(2);
      rd(timer8_pkg::ADDR_COUNT, 32'hFE);
      chk(wave_out_bit, 1'b1);
      tk(252);
      rd(timer8_pkg::ADDR_COUNT, 32'h02);
      tk(1);
      chk(wave_out_bit, 1'b0);
      tk(1);
      chk(wrap_flag, 1'b1);
      tk(3);
      rd(timer8_pkg::ADDR_COUNT, 32'h03);
      chk(wave_out_bit, 1'b1);
      tk(510);
      rd(timer8_pkg::ADDR_COUNT, 32'h03);
      // fast pwm extremes: compare zero spikes, compare max holds level
      wr(timer8_pkg::ADDR_CTRL, cw(timer8_pkg::ACT_CLEAR, 2'h3));
      wr(timer8_pkg::ADDR_COMPARE, 32'h00);
      wr(timer8_pkg::ADDR_COUNT, 32'hFE);
      tk(2);
      chk(wave_out_bit, 1'b1);
      tk(1);
      chk(wave_out_bit, 1'b0);
      wr(timer8_pkg::ADDR_COMPARE, 32'hFF);
      tk(511);
      chk(wave_out_bit, 1'b1);
      // phase-correct: compare max holds high, leaving it drops at bottom
      wr(timer8_pkg::ADDR_CTRL, cw(timer8_pkg::ACT_CLEAR, 2'h1));
      tk(510);
      chk(wave_out_bit, 1'b1);
      wr(timer8_pkg::ADDR_COMPARE, 32'h40);
      tk(510);
      chk(wave_out_bit, 1'b1);
      tk(1);
      chk(wave_out_bit, 1'b0);
      // prescaled sources over whole multiples of their period
      pre_run(timer8_pkg::CS_DIV1, 8, 32'h08);
      pre_run(timer8_pkg::CS_DIV8, 64, 32'h08);
      pre_run(timer8_pkg::CS_DIV64, 512, 32'h08);
      pre_run(timer8_pkg::CS_DIV256, 512, 32'h02);
      pre_run(timer8_pkg::CS_DIV1024, 1024, 32'h01);
      // falling pin edges count; a low clock enable freezes the counter
      wr(timer8_pkg::ADDR_COUNT, 32'h0);
      wr(timer8_pkg::ADDR_CTRL, {29'h0, timer8_pkg::CS_EXT_FALL});
      tk(3);
      rd(timer8_pkg::ADDR_COUNT, 32'h03);
      @(posedge pclk);
      clk_en <= 1'b0;
      tk(2);
      @(posedge pclk);
      clk_en <= 1'b1;
      rd(timer8_pkg::ADDR_COUNT, 32'h03);
      // force strobe applies the action with no flag; it reads back zero
      wr(timer8_pkg::ADDR_FLAGS, 32'h3);
      wr(timer8_pkg::ADDR_CTRL, {25'h0, timer8_pkg::ACT_SET, 5'h00});
      wr(timer8_pkg::ADDR_CTRL, {24'h0, 1'b1, timer8_pkg::ACT_SET, 5'h00});
      chk(wave_out_bit, 1'b1);
      rd(timer8_pkg::ADDR_FLAGS, 32'h0);
      rd(timer8_pkg::ADDR_CTRL, {25'h0, timer8_pkg::ACT_SET, 5'h00});
      end_of_test();
   end
endmodule
`default_nettype wire
